// File: logic/rss_filter.sv
/*
 Three-flop synchroniser plus glitch filter for an asynchronous level.
 Assumes the input is a pin or foreign-domain signal; output is on clk.
*/
`timescale 1ns/100ps
module rss_filter
   import rss_pkg::*;
#(
   parameter int FILT_LEN = FILT_CYCLES
)(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Async level in, filtered level out
   input  wire logic din,
   output logic      dout
);
   // All state in one record
   typedef struct packed {
      logic       s1;
      logic       s2;
      logic       s3;
      logic [7:0] cnt;
      logic       out;
   } rss_flt_type;

   rss_flt_type st;       // Registered state
   rss_flt_type next_st;  // Next state

   // Filter: a change counts once stages two and three agree long enough
   always_comb begin
      next_st = st;
      next_st.s1 = din;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      if ((st.s2 == st.s3) && (st.s3 != st.out)) begin
         // Short pulses never reach the count limit
         if (st.cnt == 8'(FILT_LEN - 1)) begin
            next_st.out = st.s3;
            next_st.cnt = '0;
         end else begin
            next_st.cnt = st.cnt + 8'h01;
         end
      end else begin
         next_st.cnt = '0;
      end
   end

   // State register; pin idles high so reset value is released
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, cnt: 8'h00, out: 1'b1};
      end else begin
         st <= next_st;
      end
   end

   assign dout = st.out;
endmodule

// File: logic/rss_supervisor.sv
/*
 Reset source supervisor: brown-out modes, pin gating, reset causes,
 power-up timer and start-up release order.
 Assumes analog monitors and the pin are asynchronous; event inputs from
 the core and watchdog are one-cycle pulses on clk. rst_n is power-on.
*/
`timescale 1ns/100ps
module rss_supervisor
   import rss_pkg::*;
#(
   parameter int PWRUP_LEN = PWRUP_CYCLES,
   parameter int FILT_LEN  = FILT_CYCLES
)(
   // Clock and power-on reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Configuration bits
   input  wire logic [1:0]       brownout_mode_cfg,
   input  wire logic             low_power_brownout_cfg,
   input  wire logic             master_clear_pin_enable,
   input  wire logic             low_voltage_program_cfg,
   input  wire logic             stack_reset_enable_cfg,
   input  wire logic             powerup_timer_disable_cfg,
   // Analog monitors (async)
   input  wire logic             brownout_trip,
   input  wire logic             brownout_det_ready,
   input  wire logic             low_power_brownout_trip,
   // External pin (async)
   input  wire logic             master_clear_pin,
   output logic                  master_clear_pin_oe,
   output logic                  master_clear_gpio,
   output logic                  master_clear_pullup_en,
   input  wire logic             sw_pullup_ctrl,
   // Core and watchdog events (pulses on clk), sleep and oscillator levels
   input  wire logic             sleep_active,
   input  wire logic             wdt_timeout,
   input  wire logic             wdt_window_violation,
   input  wire logic             reset_instr,
   input  wire logic             stack_overflow,
   input  wire logic             stack_underflow,
   input  wire logic             prog_mode_exit,
   input  wire logic             exec_invalid_fetch,
   input  wire logic             exec_fetch_valid,
   input  wire logic             osc_startup_done,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic [7:0]            reg_rdata,
   // Outputs to the core
   output logic                  brownout_enable,
   output logic                  brownout_reset,
   output logic                  core_reset,
   output logic                  wake_hold,
   output logic                  irq_block
);
   typedef enum logic [1:0] {
      ST_HOLD,     // Source active, timer idle
      ST_PWRUP,    // Power-up timer running
      ST_WAIT,     // Waiting for oscillator, pin, detector
      ST_RUN       // Core released
   } rss_state_type;

   // All state in one record
   typedef struct packed {
      rss_state_type  fsm;
      logic [TMR_W-1:0] tmr;
      logic           sw_en;        // Software brown-out enable
      logic [7:0]     pctl;         // Power control flags
      logic           exec_violation_flag;         // Execution violation flag (1 = none)
      logic [7:0]     rdata;
      logic           evt_reset;    // One-cycle core reset from event
      logic           por_pend;     // Power-on style reset in progress
   } rss_core_type;

   rss_core_type st;       // Registered state
   rss_core_type next_st;  // Next state

   // Synchronised analog and pin levels
   logic bo_trip_s;
   logic bo_rdy_s;
   logic lp_trip_s;
   logic pin_s;
   logic pin_en;           // Pin reset function enabled
   logic pin_hold;         // Pin currently holds reset
   logic bo_on;            // Detector should be running
   logic bo_start_wait;    // Start-up waits for detector
   logic bo_event;         // Common brown-out reset request
   logic stk_event;
   logic evt_any;
   logic pwrup_en;

   // Monitors and pin cross through the synchroniser and filter
   rss_filter #(.FILT_LEN(1)) u_bo_trip (
      .clk  (clk),
      .rst_n(rst_n),
      .din  (~brownout_trip),
      .dout (bo_trip_s)
   );
   rss_filter #(.FILT_LEN(1)) u_bo_rdy (
      .clk  (clk),
      .rst_n(rst_n),
      .din  (brownout_det_ready),
      .dout (bo_rdy_s)
   );
   rss_filter #(.FILT_LEN(1)) u_lp_trip (
      .clk  (clk),
      .rst_n(rst_n),
      .din  (~low_power_brownout_trip),
      .dout (lp_trip_s)
   );
   // Pin path gets the long filter so short pulses are ignored
   rss_filter #(.FILT_LEN(FILT_LEN)) u_pin (
      .clk  (clk),
      .rst_n(rst_n),
      .din  (master_clear_pin),
      .dout (pin_s)
   );

   // Brown-out mode decode and source merge
   always_comb begin
      bo_on = 1'b0;
      bo_start_wait = 1'b0;
      unique case (brownout_mode_cfg)
         BO_MODE_ALWAYS: begin
            bo_on = 1'b1;
            bo_start_wait = 1'b1;
         end
         BO_MODE_SLEEP: begin
            bo_on = ~sleep_active;
            bo_start_wait = 1'b1;
         end
         BO_MODE_SW: begin
            // Sleep plays no part in this mode
            bo_on = st.sw_en;
         end
         BO_MODE_OFF: begin
            bo_on = 1'b0;
         end
      endcase
   end

   // Trip counts only once the detector reports ready
   // Low-power monitor merges in only when its config bit is set
   assign bo_event = (bo_on & bo_rdy_s & ~bo_trip_s)
                   | (low_power_brownout_cfg & ~lp_trip_s);
   assign pin_en   = low_voltage_program_cfg
                   | master_clear_pin_enable;
   assign pin_hold = pin_en & ~pin_s;
   assign stk_event = stack_reset_enable_cfg
                    & (stack_overflow | stack_underflow);
   assign evt_any  = wdt_timeout | wdt_window_violation | reset_instr
                   | stk_event | (exec_invalid_fetch & ~exec_fetch_valid);
   assign pwrup_en = ~powerup_timer_disable_cfg;

   // Next-state logic: flags, registers, start-up sequence
   always_comb begin
      next_st = st;
      next_st.evt_reset = 1'b0;
      next_st.rdata = 8'h00;
      // Software access first so hardware updates below win
      if (reg_wr) begin
         unique case (reg_addr)
            ADDR_BO_CONTROL: next_st.sw_en = reg_wdata[BOC_SW_EN_BIT];
            ADDR_POWER_CTRL: next_st.pctl = reg_wdata;
            ADDR_POWER_CTRL_2: next_st.exec_violation_flag = reg_wdata[PC2_EXEC_VIOLATION_FLAG_BIT];
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_BO_CONTROL: begin
               // Unused bits 6..1 stay zero
               next_st.rdata[BOC_SW_EN_BIT] = st.sw_en;
               next_st.rdata[BOC_READY_BIT] = bo_on & bo_rdy_s;
            end
            ADDR_POWER_CTRL: next_st.rdata = st.pctl;
            ADDR_POWER_CTRL_2: next_st.rdata[PC2_EXEC_VIOLATION_FLAG_BIT] = st.exec_violation_flag;
            default: next_st.rdata = 8'h00;   // Unmapped reads zero
         endcase
      end
      // Event sources: only the owning flag moves
      if (wdt_timeout) begin
         next_st.pctl[PC_WDT_BIT] = 1'b0;
      end
      if (wdt_window_violation) begin
         next_st.pctl[PC_WIN_VIOL_BIT] = 1'b0;
      end
      if (reset_instr) begin
         next_st.pctl[PC_RI_BIT] = 1'b0;
      end
      if (stk_event && stack_overflow) begin
         next_st.pctl[PC_STK_OVF_BIT] = 1'b1;
      end
      if (stk_event && stack_underflow) begin
         next_st.pctl[PC_STK_UNF_BIT] = 1'b1;
      end
      // Prefetch alone is harmless; execution trips at once
      if (exec_invalid_fetch && !exec_fetch_valid) begin
         next_st.exec_violation_flag = 1'b0;
      end
      if (evt_any) begin
         next_st.evt_reset = 1'b1;
      end
      if (pin_hold && st.fsm == ST_RUN) begin
         next_st.pctl[PC_MASTER_CLEAR_PIN_BIT] = 1'b0;
      end
      // Brown-out and programming exit restart the power-up path
      if (bo_event) begin
         next_st.pctl[PC_BOR_BIT] = 1'b0;
         next_st.sw_en = 1'b1;
         next_st.por_pend = 1'b1;
         next_st.fsm = ST_HOLD;
         next_st.tmr = '0;
      end else if (prog_mode_exit) begin
         // Behaves like a fresh power-on
         next_st.pctl = POWER_CTRL_POR;
         next_st.exec_violation_flag = POWER_CTRL2_POR[PC2_EXEC_VIOLATION_FLAG_BIT];
         next_st.sw_en = 1'b1;
         next_st.por_pend = 1'b1;
         next_st.fsm = ST_HOLD;
         next_st.tmr = '0;
      end else begin
         unique case (st.fsm)
            ST_HOLD: begin
               // Timer starts on release of the supply reset
               next_st.tmr = '0;
               next_st.fsm = (st.por_pend && pwrup_en) ? ST_PWRUP : ST_WAIT;
            end
            ST_PWRUP: begin
               // Runs regardless of the pin
               if (st.tmr == TMR_W'(PWRUP_LEN - 1)) begin
                  next_st.fsm = ST_WAIT;
               end else begin
                  next_st.tmr = st.tmr + TMR_W'(1);
               end
            end
            ST_WAIT: begin
               // Timer, oscillator, pin, then detector where it gates
               if ((osc_startup_done || !st.por_pend) && !pin_hold
                   && (!bo_start_wait || bo_rdy_s || !st.por_pend)) begin
                  next_st.fsm = ST_RUN;
                  next_st.por_pend = 1'b0;
               end
            end
            ST_RUN: begin
               if (pin_hold) begin
                  next_st.fsm = ST_WAIT;
               end
            end
         endcase
      end
   end

   // State register; power-on defaults
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '{fsm: ST_HOLD, tmr: '0, sw_en: 1'b1,
                 pctl: POWER_CTRL_POR, exec_violation_flag: 1'b1, rdata: 8'h00,
                 evt_reset: 1'b0, por_pend: 1'b1};
      end else begin
         st <= next_st;
      end
   end

   // Outputs
   assign reg_rdata       = st.rdata;
   assign brownout_enable = bo_on;
   assign brownout_reset  = bo_event;
   // Held until every source and timer has let go
   assign core_reset      = (st.fsm != ST_RUN) | st.evt_reset;
   // Wake waits for the detector that was off in sleep
   assign wake_hold = (brownout_mode_cfg == BO_MODE_SLEEP) & ~bo_rdy_s;
   // Violation ignores any interrupt in the same cycle
   assign irq_block = exec_invalid_fetch & ~exec_fetch_valid;
   // Pin is never driven by the device
   assign master_clear_pin_oe    = 1'b0;
   // Disabled function leaves a plain input
   assign master_clear_gpio      = pin_s & ~pin_en;
   assign master_clear_pullup_en = pin_en | sw_pullup_ctrl;
endmodule

// File: pkg/rss_pkg.sv
/*
 Constants, register layout and timing for the reset source supervisor.
 Assumes a single 25 MHz system clock; no other dependencies.
*/
package rss_pkg;
   // Brown-out mode configuration codes
   localparam logic [1:0] BO_MODE_ALWAYS = 2'h3;
   localparam logic [1:0] BO_MODE_SLEEP  = 2'h2;
   localparam logic [1:0] BO_MODE_SW     = 2'h1;
   localparam logic [1:0] BO_MODE_OFF    = 2'h0;
   // Register index map
   localparam int         ADDR_W             = 4;
   localparam logic [3:0] ADDR_BO_CONTROL    = 4'h0;
   localparam logic [3:0] ADDR_POWER_CTRL    = 4'h1;
   localparam logic [3:0] ADDR_POWER_CTRL_2  = 4'h2;
   // Brown-out control fields
   localparam int         BOC_SW_EN_BIT   = 7;
   localparam int         BOC_READY_BIT   = 0;
   // Power control fields
   localparam int         PC_STK_OVF_BIT  = 7;
   localparam int         PC_STK_UNF_BIT  = 6;
   localparam int         PC_WIN_VIOL_BIT = 5;
   localparam int         PC_WDT_BIT      = 4;
   localparam int         PC_MASTER_CLEAR_PIN_BIT     = 3;
   localparam int         PC_RI_BIT       = 2;
   localparam int         PC_POR_BIT      = 1;
   localparam int         PC_BOR_BIT      = 0;
   localparam int         PC2_EXEC_VIOLATION_FLAG_BIT    = 1;
   // Reset values
   localparam logic [7:0] POWER_CTRL_POR  = 8'h3c;
   localparam logic [7:0] POWER_CTRL2_POR = 8'h02;
   // Timing
   localparam int CLK_HZ         = 25_000_000;
   localparam int PWRUP_TIME_MS  = 64;
   localparam int PWRUP_CYCLES   = PWRUP_TIME_MS * (CLK_HZ / 1000);
   localparam int FILT_CYCLES    = 8;
   localparam int TMR_W          = 21;
endpackage

// File: verif/rss_far_model.sv
/* Model of the master-clear pin driver and the supply monitors.
 Assumes the bench commands dips and pin holds on clk. */
`timescale 1ns/100ps
module rss_far_model (
   // Clock and power-on reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Commands from the bench
   input  wire logic hold_low,
   input  wire logic supply_dip,
   input  wire logic lp_dip,
   input  wire logic slow,
   // Pin and monitor levels
   output logic      master_clear_pin,
   output logic      brownout_trip,
   output logic      brownout_det_ready,
   output logic      low_power_brownout_trip,
   output logic      osc_startup_done
);
   logic [5:0] age; // Cycles since power-on or the last supply dip

   // Age saturates so readiness never drops by itself
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         age <= 6'h00;
      end else if (supply_dip) begin
         age <= 6'h00;
      end else if (age != 6'h3f) begin
         age <= age + 6'h01;
      end
   end
   // Weak pull-up restores the pin once released
   assign master_clear_pin = hold_low ? 1'b0 : 1'b1;
   // Monitor requests follow the commanded dips
   assign brownout_trip = supply_dip;
   assign low_power_brownout_trip = lp_dip;
   // Slow mode keeps the detector unready well past power-up
   assign brownout_det_ready = age >= (slow ? 6'h30 : 6'h04);
   assign osc_startup_done = age >= 6'h08;
endmodule

// File: verif/rss_supervisor_properties.sv
/* Port checker for the reset source supervisor.
 Assumes it is bound to rss_supervisor and sees only its ports. */
`timescale 1ns/100ps
module rss_checker
   import rss_pkg::*;
(
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // Inputs that cause the watched behaviour
   input wire logic [1:0] brownout_mode_cfg,
   input wire logic       master_clear_pin_enable,
   input wire logic       low_voltage_program_cfg,
   input wire logic       stack_reset_enable_cfg,
   input wire logic       sw_pullup_ctrl,
   input wire logic       sleep_active,
   input wire logic       wdt_timeout,
   input wire logic       reset_instr,
   input wire logic       stack_overflow,
   input wire logic       exec_invalid_fetch,
   input wire logic       exec_fetch_valid,
   input wire logic       reg_rd,
   // Watched outputs
   input wire logic       master_clear_pin_oe,
   input wire logic       master_clear_gpio,
   input wire logic       master_clear_pullup_en,
   input wire logic [7:0] reg_rdata,
   input wire logic       brownout_enable,
   input wire logic       core_reset,
   input wire logic       wake_hold,
   input wire logic       irq_block
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Pin function enable, shared by the pin checks
   wire logic pin_en = master_clear_pin_enable | low_voltage_program_cfg;

   a_pin_not_driven: assert property (!master_clear_pin_oe)
      else $error("pin driven");
   a_pullup_select: assert property (
      master_clear_pullup_en == (pin_en | sw_pullup_ctrl))
      else $error("pull-up select wrong");
   a_gpio_gated: assert property (pin_en |-> !master_clear_gpio)
      else $error("gpio live while pin enabled");
   a_mode_off: assert property (
      brownout_mode_cfg == BO_MODE_OFF |-> !brownout_enable)
      else $error("detector on in off mode");
   a_mode_always: assert property (
      brownout_mode_cfg == BO_MODE_ALWAYS |-> brownout_enable)
      else $error("detector off in always mode");
   a_sleep_off: assert property (brownout_mode_cfg == BO_MODE_SLEEP
      |-> brownout_enable == !sleep_active)
      else $error("detector wrong around sleep");
   a_wake_only: assert property (
      brownout_mode_cfg != BO_MODE_SLEEP |-> !wake_hold)
      else $error("wake held outside sleep mode");
   a_instr_reset: assert property (reset_instr |=> core_reset)
      else $error("no reset after instruction");
   a_wdt_reset: assert property (wdt_timeout |=> core_reset)
      else $error("no reset after time-out");
   a_stack_reset: assert property (
      stack_overflow && stack_reset_enable_cfg |=> core_reset)
      else $error("no reset after overflow");
   a_viol_block: assert property (
      irq_block == (exec_invalid_fetch && !exec_fetch_valid))
      else $error("interrupt block wrong");
   a_viol_reset: assert property (
      exec_invalid_fetch && !exec_fetch_valid |=> core_reset)
      else $error("no reset after violation");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside answer cycle");
endmodule

// File: verif/rss_supervisor_tb_top.sv
/* Self-checking bench for the reset source supervisor.
 Assumes rss_pkg, the design, the checker and the model come first. */
`timescale 1ns/100ps
module rss_supervisor_tb_top;
   import rss_pkg::*;
   localparam int PW = 30; // Short power-up count keeps runs brief
   // Design inputs and read data
   logic        clk, rst_n, low_power_brownout_cfg, sleep_active;
   logic        master_clear_pin_enable, low_voltage_program_cfg;
   logic        stack_reset_enable_cfg, powerup_timer_disable_cfg;
   logic        sw_pullup_ctrl, exec_fetch_valid, reg_wr, reg_rd;
   logic [1:0]  brownout_mode_cfg;
   logic [6:0]  ev; // Event pulses, one bit each
   logic        wdt_timeout, wdt_window_violation, reset_instr;
   logic        stack_overflow, stack_underflow, prog_mode_exit;
   logic        exec_invalid_fetch;
   logic [3:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata;
   // Model commands, model levels, design outputs
   logic        hold_low, supply_dip, lp_dip, slow, master_clear_pin;
   logic        brownout_trip, brownout_det_ready, low_power_brownout_trip;
   logic        osc_startup_done, master_clear_pin_oe, master_clear_gpio;
   logic        master_clear_pullup_en, brownout_enable, brownout_reset;
   logic        core_reset, wake_hold, irq_block;
   int          n_fail, cmp_count, n;
   logic [31:0] rnd;
   // Flag value before and after each of five event causes
   logic [7:0]  bse [5] = '{8'hff, 8'hff, 8'hff, 8'h3f, 8'h3f};
   logic [7:0]  aft [5] = '{8'hef, 8'hdf, 8'hfb, 8'hbf, 8'h7f};

   assign {wdt_timeout, wdt_window_violation, reset_instr, stack_overflow,
           stack_underflow, prog_mode_exit, exec_invalid_fetch} = ev;
   rss_supervisor #(.PWRUP_LEN(PW)) i_dut (.*);
   rss_far_model i_far (.*);

   // Repeatable pseudo-random source
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      if (n_fail == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, e);
   endtask
   task automatic fire(input int b);
      @(posedge clk);
      ev <= 7'h01 << b;
      @(posedge clk);
      ev <= 7'h00;
   endtask
   // Bounded wait for release; a hang shows as a mismatch
   task automatic wait_run(output int c);
      c = 0;
      #1;
      while (core_reset !== 1'b0 && c < 400) begin
         @(posedge clk);
         #1 c++;
      end
      check({7'h0, core_reset}, 8'h00);
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Watchdog well beyond the expected run length
   initial begin
      #(40 * 8000);
      n_fail++;
      test_done();
   end
   initial begin
      {rst_n, ev, reg_wr, reg_rd, reg_addr, reg_wdata, sleep_active} = '0;
      {low_power_brownout_cfg, low_voltage_program_cfg, sw_pullup_ctrl} = '0;
      {powerup_timer_disable_cfg, hold_low, supply_dip, lp_dip} = '0;
      {master_clear_pin_enable, stack_reset_enable_cfg, slow} = '1;
      exec_fetch_valid = 1'b0;
      brownout_mode_cfg = BO_MODE_ALWAYS;
      n_fail = 0;
      cmp_count = 0;
      rnd = 32'h0000_003a;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      // Power-up count ends first; unready detector still holds
      repeat (38) @(posedge clk);
      #1 check({7'h0, core_reset}, 8'h01);
      wait_run(n);
      chk_rd(ADDR_BO_CONTROL, 8'h81);
      chk_rd(ADDR_POWER_CTRL, 8'h3c);
      chk_rd(4'hf, 8'h00);
      wr_reg(ADDR_BO_CONTROL, 8'h7e);
      chk_rd(ADDR_BO_CONTROL, 8'h01);
      wr_reg(ADDR_BO_CONTROL, 8'hff);
      for (int k = 0; k < 5; k++) begin
         wr_reg(ADDR_POWER_CTRL, bse[k]);
         fire(6 - k);
         wait_run(n);
         chk_rd(ADDR_POWER_CTRL, aft[k]);
      end
      stack_reset_enable_cfg <= 1'b0;
      wr_reg(ADDR_POWER_CTRL, 8'h3f);
      fire(3);
      #1 check({7'h0, core_reset}, 8'h00);
      chk_rd(ADDR_POWER_CTRL, 8'h3f);
      wr_reg(ADDR_POWER_CTRL_2, 8'hff);
      chk_rd(ADDR_POWER_CTRL_2, 8'h02);
      exec_fetch_valid <= 1'b1;
      fire(0);
      #1 check({7'h0, core_reset}, 8'h00);
      exec_fetch_valid <= 1'b0;
      fire(0);
      wait_run(n);
      chk_rd(ADDR_POWER_CTRL_2, 8'h00);
      // Short glitch is filtered, long hold resets
      wr_reg(ADDR_POWER_CTRL, 8'hff);
      hold_low <= 1'b1;
      repeat (3) @(posedge clk);
      hold_low <= 1'b0;
      repeat (20) @(posedge clk);
      chk_rd(ADDR_POWER_CTRL, 8'hff);
      hold_low <= 1'b1;
      repeat (30) @(posedge clk);
      #1 check({7'h0, core_reset}, 8'h01);
      hold_low <= 1'b0;
      wait_run(n);
      chk_rd(ADDR_POWER_CTRL, 8'hf7);
      fire(1);
      repeat (15) @(posedge clk);
      #1 check({7'h0, core_reset}, 8'h01);
      wait_run(n);
      // Timer runs on while the pin is held, so release is quick
      hold_low <= 1'b1;
      fire(1);
      repeat (60) @(posedge clk);
      hold_low <= 1'b0;
      wait_run(n);
      check(8'(n < PW), 8'h01);
      brownout_mode_cfg <= BO_MODE_SW;
      low_power_brownout_cfg <= 1'b1;
      wr_reg(ADDR_BO_CONTROL, 8'h00);
      chk_rd(ADDR_BO_CONTROL, 8'h00);
      wr_reg(ADDR_POWER_CTRL, 8'hff);
      lp_dip <= 1'b1;
      repeat (6) @(posedge clk);
      lp_dip <= 1'b0;
      wait_run(n);
      chk_rd(ADDR_POWER_CTRL, 8'hfe);
      chk_rd(ADDR_BO_CONTROL, 8'h81);
      sleep_active <= 1'b1;
      @(posedge clk);
      #1 check({7'h0, brownout_enable}, 8'h01);
      brownout_mode_cfg <= BO_MODE_SLEEP;
      @(posedge clk);
      #1 check({7'h0, brownout_enable}, 8'h00);
      brownout_mode_cfg <= BO_MODE_SW;
      sleep_active <= 1'b0;
      repeat (16) begin
         rnd = xs(rnd);
         master_clear_pin_enable <= rnd[0];
         low_voltage_program_cfg <= rnd[1];
         sw_pullup_ctrl <= rnd[2];
         wr_reg(ADDR_BO_CONTROL, rnd[15:8]);
         #1 check({7'h0, master_clear_pullup_en}, {7'h0, |rnd[2:0]});
         check({7'h0, brownout_enable}, {7'h0, rnd[15]});
         chk_rd(ADDR_BO_CONTROL, {rnd[15], 6'h00, rnd[15]});
      end
      // Disabled pin is a plain input and never resets
      master_clear_pin_enable <= 1'b0;
      low_voltage_program_cfg <= 1'b0;
      hold_low <= 1'b1;
      repeat (30) @(posedge clk);
      #1 check({6'h0, core_reset, master_clear_gpio}, 8'h00);
      hold_low <= 1'b0;
      // Main detector dip with the power-up timer off; ready still gates
      brownout_mode_cfg <= BO_MODE_ALWAYS;
      powerup_timer_disable_cfg <= 1'b1;
      wr_reg(ADDR_POWER_CTRL, 8'hff);
      supply_dip <= 1'b1;
      repeat (6) @(posedge clk);
      supply_dip <= 1'b0;
      repeat (20) @(posedge clk);
      #1 check({7'h0, core_reset}, 8'h01);
      wait_run(n);
      chk_rd(ADDR_POWER_CTRL, 8'hfe);
      test_done();
   end
endmodule

bind rss_supervisor rss_checker i_chk (.*);
